// >>> rtl/dpbm_mem.sv
// dual-port block memory: shared 512 x (32+4) array, two ports of set width
// assumes user logic drives both request structs synchronously to clk
`timescale 1ns/1ps
module dpbm_mem #(
  parameter int                    WIDTH_A  = 36,
  parameter int                    WIDTH_B  = 36,
  parameter dpbm_pkg::dpbm_wmode_t MODE_A   = dpbm_pkg::DPBM_SHOW_NEW,
  parameter dpbm_pkg::dpbm_wmode_t MODE_B   = dpbm_pkg::DPBM_SHOW_NEW,
  parameter logic [3:0]            INV_A    = 4'h0,
  parameter logic [3:0]            INV_B    = 4'h0,
  parameter dpbm_pkg::dpbm_rsp_t   INIT_A   = dpbm_pkg::RSP_ZERO,
  parameter dpbm_pkg::dpbm_rsp_t   INIT_B   = dpbm_pkg::RSP_ZERO,
  parameter dpbm_pkg::dpbm_rsp_t   PRESET_A = dpbm_pkg::RSP_ZERO,
  parameter dpbm_pkg::dpbm_rsp_t   PRESET_B = dpbm_pkg::RSP_ZERO,
  parameter logic [16383:0]        CONTENT_PRELOAD    = '0,
  parameter logic [2047:0]         EXTRA_BITS_PRELOAD = '0
) (
  // system
  input  wire logic                clk,
  input  wire logic                reset,
  // port a
  input  wire dpbm_pkg::dpbm_req_t port_a_req,
  output dpbm_pkg::dpbm_rsp_t      port_a_rsp,
  // port b
  input  wire dpbm_pkg::dpbm_req_t port_b_req,
  output dpbm_pkg::dpbm_rsp_t      port_b_rsp
);
  import dpbm_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [DATA_W-1:0]  data_mem  [ROWS];
  logic [EXTRA_W-1:0] extra_mem [ROWS];

  // preload stands for configuration-time content, not a reset action
  initial begin
    for (int r = 0; r < ROWS; r++) begin
      data_mem[r]  = CONTENT_PRELOAD[r*DATA_W +: DATA_W];
      extra_mem[r] = EXTRA_BITS_PRELOAD[r*EXTRA_W +: EXTRA_W];
    end
  end

  // per-port wires toward the shared array
  dpbm_req_t          req      [2];
  dpbm_rsp_t          rsp_reg  [2];
  logic               wr_en    [2];
  logic [ROW_W-1:0]   wr_row   [2];
  logic [DATA_W-1:0]  wr_dmask [2];
  logic [DATA_W-1:0]  wr_dbits [2];
  logic [EXTRA_W-1:0] wr_emask [2];
  logic [EXTRA_W-1:0] wr_ebits [2];

  assign req[0]     = port_a_req;
  assign req[1]     = port_b_req;
  assign port_a_rsp = rsp_reg[0];
  assign port_b_rsp = rsp_reg[1];

  // ****************************************************************
  // per-port access logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      localparam int W      = (gi == 0) ? WIDTH_A : WIDTH_B;
      localparam int P      = W / EXTRA_DIVISOR;
      localparam int DW     = W - P;
      localparam int LOG_DW = $clog2(DW);
      localparam int SH     = LANE_W - LOG_DW;
      localparam int R      = ADDR_W - LOG_DW;
      localparam logic [ADDR_W-1:0] AMASK =
        ADDR_W'((32'h1 << R) - 32'h1);
      localparam logic [LANE_W-1:0] LMASK =
        LANE_W'((32'h1 << SH) - 32'h1);
      localparam logic [DATA_W-1:0] DMASK =
        DATA_W'((64'h1 << DW) - 64'h1);
      localparam logic [EXTRA_W-1:0] EMASK =
        EXTRA_W'((32'h1 << P) - 32'h1);
      localparam dpbm_wmode_t MODE = (gi == 0) ? MODE_A : MODE_B;
      localparam dpbm_rsp_t   INIT = (gi == 0) ? INIT_A : INIT_B;
      localparam dpbm_rsp_t   PRE  = (gi == 0) ? PRESET_A : PRESET_B;
      localparam logic [3:0]  INV  = (gi == 0) ? INV_A : INV_B;

      logic               edge_hit;
      logic               gate;
      logic               store;
      logic               preset;
      logic [ADDR_W-1:0]  addr_used;
      logic [ROW_W-1:0]   row;
      logic [LANE_W-1:0]  lane;
      logic [LANE_W-1:0]  dpos;
      logic [1:0]         epos;
      logic               active;
      dpbm_rsp_t          old_word;
      dpbm_rsp_t          new_word;
      dpbm_rsp_t          init_word;
      dpbm_rsp_t          pre_word;
      dpbm_rsp_t          rsp_next;

      dpbm_strobe #(
        .INV      (INV)
      ) u_strobe (
        .clk      (clk),
        .reset    (reset),
        .req      (req[gi]),
        .edge_hit (edge_hit),
        .gate     (gate),
        .store    (store),
        .preset   (preset)
      );

      // narrow ports address lanes inside one 36-bit row
      assign addr_used = req[gi].addr & AMASK;
      assign row       = ROW_W'(addr_used >> SH);
      assign lane      = LANE_W'(addr_used) & LMASK;
      assign dpos      = LANE_W'(lane * DW);
      assign epos      = 2'(lane * P);
      assign active    = edge_hit & gate;

      // a same-row access by the other port reads the pre-write contents
      assign old_word.read_word_out  = (data_mem[row] >> dpos) & DMASK;
      assign old_word.extra_bits_out = (extra_mem[row] >> epos) & EMASK;
      assign new_word.read_word_out  = req[gi].write_word_in & DMASK;
      assign new_word.extra_bits_out = req[gi].extra_bits_in & EMASK;
      assign init_word.read_word_out  = INIT.read_word_out & DMASK;
      assign init_word.extra_bits_out = INIT.extra_bits_out & EMASK;
      assign pre_word.read_word_out   = PRE.read_word_out & DMASK;
      assign pre_word.extra_bits_out  = PRE.extra_bits_out & EMASK;

      assign wr_en[gi]    = active & store;
      assign wr_row[gi]   = row;
      assign wr_dmask[gi] = DMASK << dpos;
      assign wr_emask[gi] = EMASK << epos;
      assign wr_dbits[gi] = new_word.read_word_out << dpos;
      assign wr_ebits[gi] = new_word.extra_bits_out << epos;

      always_comb begin
        rsp_next = rsp_reg[gi];
        if (preset) begin
          rsp_next = pre_word;
        end else if (store) begin
          case (MODE)
            DPBM_SHOW_NEW: rsp_next = new_word;
            DPBM_SHOW_OLD: rsp_next = old_word;
            DPBM_HOLD_OUT: rsp_next = rsp_reg[gi];
            default:       rsp_next = rsp_reg[gi];
          endcase
        end else begin
          rsp_next = old_word;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          rsp_reg[gi] <= init_word;
        end else if (active) begin
          rsp_reg[gi] <= rsp_next;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // shared write path
  // ****************************************************************
  // port b is applied last, so on a same-row collision its whole-row update wins and port a's write to that row is lost
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_en[p]) begin
        data_mem[wr_row[p]]  <= (data_mem[wr_row[p]] & ~wr_dmask[p]) | wr_dbits[p];
        extra_mem[wr_row[p]] <= (extra_mem[wr_row[p]] & ~wr_emask[p]) | wr_ebits[p];
      end
    end
  end

endmodule : dpbm_mem

// >>> rtl/dpbm_pkg.sv
// dual-port block memory: shared constants, types and configuration encodings
// assumes one system clock; port clock pins are plain synchronous inputs
// ****************************************************************
// ****************************************************************
package dpbm_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int ROWS          = 512;
  localparam int ROW_W         = 9;
  localparam int DATA_W        = 32;
  localparam int EXTRA_W       = 4;
  localparam int ADDR_W        = 14;
  localparam int LANE_W        = 5;
  localparam int CONTENT_BITS  = 16384;
  localparam int EXTRA_BITS    = 2048;
  localparam int EXTRA_DIVISOR = 9;

  // ****************************************************************
  // control inversion bit positions
  // ****************************************************************
  localparam int INV_CLK    = 0;
  localparam int INV_GATE   = 1;
  localparam int INV_STORE  = 2;
  localparam int INV_PRESET = 3;
  localparam int INV_W      = 4;

  // output behaviour while the store strobe is active
  typedef enum logic [2:0] {
    DPBM_SHOW_NEW  = 3'h1,
    DPBM_SHOW_OLD  = 3'h2,
    DPBM_HOLD_OUT  = 3'h4
  } dpbm_wmode_t;

  typedef struct packed {
    logic                clk_pin;
    logic                gate;
    logic                store;
    logic                output_sync_preset;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   write_word_in;
    logic [EXTRA_W-1:0]  extra_bits_in;
  } dpbm_req_t;

  typedef struct packed {
    logic [EXTRA_W-1:0]  extra_bits_out;
    logic [DATA_W-1:0]   read_word_out;
  } dpbm_rsp_t;

  localparam dpbm_rsp_t RSP_ZERO = '0;

endpackage : dpbm_pkg

// >>> rtl/dpbm_strobe.sv
// dual-port block memory: per-port control polarity and clock edge detect
// assumes the port clock pin runs well below half the system clock rate
`timescale 1ns/1ps
module dpbm_strobe #(
  parameter logic [3:0] INV = 4'h0
) (
  // system
  input  wire logic             clk,
  input  wire logic             reset,
  // raw port controls
  input  wire dpbm_pkg::dpbm_req_t req,
  // decoded controls
  output logic                  edge_hit,
  output logic                  gate,
  output logic                  store,
  output logic                  preset
);
  import dpbm_pkg::*;

  logic pin_prev_reg;
  logic seen_reg;
  logic pin_now;

  // ****************************************************************
  // polarity
  // ****************************************************************
  assign pin_now = req.clk_pin ^ INV[INV_CLK];
  assign gate    = req.gate ^ INV[INV_GATE];
  assign store   = req.store ^ INV[INV_STORE];
  assign preset  = req.output_sync_preset ^ INV[INV_PRESET];

  // first sample after reset only primes the history, so no false edge
  assign edge_hit = seen_reg & pin_now & ~pin_prev_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_prev_reg <= 1'b0;
      seen_reg     <= 1'b0;
    end else begin
      pin_prev_reg <= pin_now;
      seen_reg     <= 1'b1;
    end
  end

endmodule : dpbm_strobe

// >>> verification/dpbm_mem_checker.sv
// checker: port behaviour of the dual-port memory
// assumes no control inversion; init and preset values come in masked
`timescale 1ns/1ps
module dpbm_mem_checker #(
  parameter int                    WIDTH_A  = 36,
  parameter int                    WIDTH_B  = 36,
  parameter dpbm_pkg::dpbm_wmode_t MODE_A   = dpbm_pkg::DPBM_SHOW_NEW,
  parameter dpbm_pkg::dpbm_wmode_t MODE_B   = dpbm_pkg::DPBM_SHOW_NEW,
  parameter dpbm_pkg::dpbm_rsp_t   INIT_A   = dpbm_pkg::RSP_ZERO,
  parameter dpbm_pkg::dpbm_rsp_t   INIT_B   = dpbm_pkg::RSP_ZERO,
  parameter dpbm_pkg::dpbm_rsp_t   PRESET_A = dpbm_pkg::RSP_ZERO,
  parameter dpbm_pkg::dpbm_rsp_t   PRESET_B = dpbm_pkg::RSP_ZERO
) (
  // system
  input wire logic                clk,
  input wire logic                reset,
  // ports
  input wire dpbm_pkg::dpbm_req_t port_a_req,
  input wire dpbm_pkg::dpbm_rsp_t port_a_rsp,
  input wire dpbm_pkg::dpbm_req_t port_b_req,
  input wire dpbm_pkg::dpbm_rsp_t port_b_rsp
);
  import dpbm_pkg::*;
  localparam int DW_B = (WIDTH_B % 9 == 0) ? WIDTH_B / 9 * 8 : WIDTH_B;
  localparam int P_B  = (WIDTH_B % 9 == 0) ? WIDTH_B / 9 : 0;
  logic pin_a_q;
  logic pin_b_q;
  logic hit_a;
  logic hit_b;
  // held high in reset so the first sample after release cannot count as an edge
  always_ff @(posedge clk) begin
    pin_a_q <= reset | port_a_req.clk_pin;
    pin_b_q <= reset | port_b_req.clk_pin;
  end
  assign hit_a = port_a_req.clk_pin & ~pin_a_q & port_a_req.gate;
  assign hit_b = port_b_req.clk_pin & ~pin_b_q & port_b_req.gate;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // assertions
  // ****
  a_out_stable_a: assert property (!hit_a |=> $stable(port_a_rsp))
    else $error("port a output moved without an enabled edge");
  b_out_stable_a: assert property (!hit_b |=> $stable(port_b_rsp))
    else $error("port b output moved without an enabled edge");
  a_preset_load_a: assert property (hit_a && port_a_req.output_sync_preset |=> port_a_rsp == PRESET_A)
    else $error("port a preset value not loaded");
  b_preset_load_a: assert property (hit_b && port_b_req.output_sync_preset |=> port_b_rsp == PRESET_B)
    else $error("port b preset value not loaded");
  a_show_new_a: assert property ((MODE_A == DPBM_SHOW_NEW) && (WIDTH_A == 36) && hit_a
    && port_a_req.store && !port_a_req.output_sync_preset |=> port_a_rsp ==
    {$past(port_a_req.extra_bits_in), $past(port_a_req.write_word_in)})
    else $error("port a write word not shown");
  b_hold_out_a: assert property ((MODE_B == DPBM_HOLD_OUT) && hit_b && port_b_req.store
    && !port_b_req.output_sync_preset |=> $stable(port_b_rsp))
    else $error("port b output changed during store");
  init_after_reset_a: assert property ($fell(reset) |-> port_a_rsp == INIT_A && port_b_rsp == INIT_B)
    else $error("output latch not at initial value after reset");
  b_width_zero_a: assert property ((port_b_rsp.read_word_out >> DW_B) == 0 && (port_b_rsp.extra_bits_out >> P_B) == 0)
    else $error("port b drives bits beyond its width");
  a_write_c: cover property (hit_a && port_a_req.store);
  b_store_c: cover property (hit_b && port_b_req.store);
  b_preset_c: cover property (hit_b && port_b_req.output_sync_preset && port_b_req.store);
endmodule : dpbm_mem_checker
bind dpbm_mem dpbm_mem_checker #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B), .MODE_A(MODE_A),
  .MODE_B(MODE_B), .INIT_A(INIT_A), .INIT_B(INIT_B), .PRESET_A(PRESET_A),
  .PRESET_B(PRESET_B)) i_dpbm_mem_checker (.clk(clk), .reset(reset),
  .port_a_req(port_a_req), .port_a_rsp(port_a_rsp), .port_b_req(port_b_req),
  .port_b_rsp(port_b_rsp));

// >>> verification/dpbm_user_port.sv
// model of the user logic on one memory port: one port-clock pulse per command
// assumes go lasts one clk and no control inversion
`timescale 1ns/1ps
module dpbm_user_port (
  // system
  input  wire logic                clk,
  input  wire logic                reset,
  // bench command
  input  wire logic                go,
  input  wire dpbm_pkg::dpbm_req_t cmd,
  // port side
  output dpbm_pkg::dpbm_req_t      req,
  output logic                     done
);
  import dpbm_pkg::*;
  logic [1:0] phase_reg;
  dpbm_req_t  launch;
  dpbm_req_t  idle;
  initial req = '0;
  initial done = 1'b0;
  initial phase_reg = 2'h0;
  // each signal gets one assignment per edge, built up in helper variables first
  always @(posedge clk) begin
    launch = cmd;
    launch.clk_pin = 1'b0;
    idle = ~req;
    idle.clk_pin = 1'b0;
    idle.gate = 1'b0;
    done <= (!reset && phase_reg == 2'h2);
    if (reset) begin
      req       <= '0;
      phase_reg <= 2'h0;
    end else if (go && phase_reg == 2'h0) begin
      req       <= launch;
      phase_reg <= 2'h1;
    end else if (phase_reg == 2'h1) begin
      req.clk_pin <= 1'b1;
      phase_reg   <= 2'h2;
    end else if (phase_reg == 2'h2) begin
      // idle: pin low, gate off, stale fields flipped so nothing lingers
      req       <= idle;
      phase_reg <= 2'h0;
    end
  end
endmodule : dpbm_user_port

// >>> verification/dpbm_mem_test.sv
// testbench: dual-port memory against a behavioural model
// assumes port a x36 show-new, port b x9 hold-output
`timescale 1ns/1ps
module dpbm_mem_test;
  import dpbm_pkg::*;
  localparam dpbm_rsp_t INIT_A_V = 36'h3_0000_0011;
  localparam dpbm_rsp_t INIT_B_V = 36'h1_0000_0044;
  localparam dpbm_rsp_t PRE_A_V  = 36'h6_0000_0022;
  localparam dpbm_rsp_t PRE_B_V  = 36'h1_0000_0033;
  logic        clk;
  logic        reset;
  logic        go [2];
  logic        done [2];
  dpbm_req_t   cmd [2];
  dpbm_req_t   req [2];
  dpbm_rsp_t   rsp [2];
  dpbm_rsp_t   exp_q [2];
  logic [31:0] md [512];
  logic [3:0]  mx [512];
  logic [15:0] lfsr;
  int          mismatches;
  int          tests_run;
  int          cycles = 0;
  dpbm_mem #(.WIDTH_B(9), .MODE_B(DPBM_HOLD_OUT), .INIT_A(INIT_A_V), .INIT_B(INIT_B_V),
    .PRESET_A(PRE_A_V), .PRESET_B(PRE_B_V), .CONTENT_PRELOAD(16384'h1234_5678),
    .EXTRA_BITS_PRELOAD(2048'h5)) i_dpbm_mem (.clk(clk), .reset(reset),
    .port_a_req(req[0]), .port_a_rsp(rsp[0]), .port_b_req(req[1]), .port_b_rsp(rsp[1]));
  dpbm_user_port i_dpbm_user_port_a (.clk(clk), .reset(reset), .go(go[0]), .cmd(cmd[0]),
    .req(req[0]), .done(done[0]));
  dpbm_user_port i_dpbm_user_port_b (.clk(clk), .reset(reset), .go(go[1]), .cmd(cmd[1]),
    .req(req[1]), .done(done[1]));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task check(input dpbm_rsp_t seen, input dpbm_rsp_t want, input string what);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // one port-clock cycle on port p; the model predicts the latch first
  task op(input int p, input logic g, input logic st, input logic ps, input logic [13:0] ad);
    dpbm_rsp_t   e;
    int          r;
    int          ln;
    int          n;
    logic [35:0] w;
    lfsr = lfsr_next(lfsr);
    w = {lfsr[3:0], lfsr, lfsr ^ 16'h5a5a};
    e = exp_q[p];
    r = (p == 0) ? int'(ad[8:0]) : int'(ad[10:2]);
    ln = int'(ad[1:0]);
    if (g) begin
      if (!st && p == 0) e = {mx[r], md[r]};
      if (!st && p == 1) e = {3'h0, mx[r][ln], 24'h0, md[r][ln*8+:8]};
      if (st && p == 0) e = w;
      if (ps) e = (p == 0) ? PRE_A_V : PRE_B_V;
      if (st && p == 0) {mx[r], md[r]} = w;
      if (st && p == 1) begin
        md[r][ln*8+:8] = w[7:0];
        mx[r][ln] = w[32];
      end
    end
    exp_q[p] = e;
    @(posedge clk);
    go[p] <= 1'b1;
    cmd[p] <= {1'b0, g, st, ps, ad, w[31:0], w[35:32]};
    @(posedge clk);
    go[p] <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done[p] !== 1'b1 && n < 8);
    check(rsp[p], e, "port response");
  endtask : op
  initial begin
    reset = 1'b1;
    lfsr = 16'h002f;
    mismatches = 0;
    tests_run = 0;
    for (int i = 0; i < 2; i++) begin
      go[i] = 1'b0;
      cmd[i] = '0;
    end
    exp_q[0] = INIT_A_V;
    exp_q[1] = INIT_B_V;
    for (int i = 0; i < 512; i++) begin
      md[i] = 32'h0;
      mx[i] = 4'h0;
    end
    md[0] = 32'h1234_5678;
    mx[0] = 4'h5;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(negedge clk);
    check(rsp[0], INIT_A_V, "init a");
    check(rsp[1], INIT_B_V, "init b");
    op(0, 1, 0, 0, 14'h0000);
    for (int i = 0; i < 4; i++) op(1, 1, 0, 0, 14'(i));
    op(0, 1, 0, 1, 14'h0000);
    op(0, 1, 1, 0, 14'h0005);
    op(0, 1, 1, 0, 14'h0006);
    for (int i = 20; i < 28; i++) op(1, 1, 0, 0, 14'(i));
    op(1, 1, 1, 0, 14'h0015);
    op(1, 1, 1, 1, 14'h0016);
    op(0, 1, 0, 0, 14'h0005);
    op(0, 0, 1, 0, 14'h0005);
    op(0, 1, 0, 0, 14'h0005);
    // random mix over a small address range so both ports reuse the same rows, one port at a time
    for (int i = 0; i < 60; i++) begin
      lfsr = lfsr_next(lfsr);
      op(int'(lfsr[0]), 1'b1, lfsr[1], lfsr[2] & lfsr[3], {8'h0, lfsr[9:4]});
    end
    final_report();
  end
endmodule : dpbm_mem_test
